// ==== rtl/smf_pkg.sv ====
package smf_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned HEAD_SETTLE_NS = 5000;
	localparam int unsigned HEAD_SETTLE_CYC = (HEAD_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WR2RD_NS = 10000;
	localparam int unsigned WR2RD_CYC = (WR2RD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RD2WR_NS = 1000;
	localparam int unsigned RD2WR_CYC = (RD2WR_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RDWR_GAP_NS = 240;
	localparam int unsigned RDWR_GAP_CYC = (RDWR_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WCLK_LEAD_NS = 250;
	localparam int unsigned BITS_PER_BYTE = 8;
	localparam int unsigned PRE_ADDR_ZEROS = 20;
	localparam int unsigned PRE_DATA_ZEROS = 12;
	localparam int unsigned DATA_CRC_BYTES = 2;
	localparam int unsigned POST_ZEROS = 5;
	localparam int unsigned BOR_GAP_BYTES = 9;
	localparam int unsigned VFO_LOCK_NS = 8000;
	localparam int unsigned WDRV_ON_NS = 960;
	localparam logic [7:0] SYNC_BYTE = 8'h19;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] TEST_BYTE = 8'hdb;
	typedef struct packed {
		logic servo_clk;
		logic index;
		logic sector;
		logic unit_sel_n;
	} smf_drv_in_t;
	typedef struct packed {
		logic write_data;
		logic write_clk;
		logic write_gate;
		logic read_gate;
		logic pwr_pick;
		logic pwr_hold;
	} smf_drv_out_t;
endpackage

// ==== rtl/smf_format_ctrl.sv ====
`timescale 1ns/1ps
module smf_format_ctrl #(
	parameter int unsigned DATA_BYTES = 256,
	parameter int unsigned HEAD_SETTLE = smf_pkg::HEAD_SETTLE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// user command
	input wire logic start_i,
	input wire logic chain_i,
	input wire logic [31:0] addr_i,
	output logic busy_o,
	output logic done_o,
	output logic selected_o,
	// drive pins
	input wire smf_pkg::smf_drv_in_t drv_i,
	output smf_pkg::smf_drv_out_t drv_o
);
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_SETTLE = 4'h1,
		S_SEEK = 4'h2,
		S_LEAD = 4'h3,
		S_PRE_A = 4'h4,
		S_SYNC_A = 4'h5,
		S_ADDR = 4'h6,
		S_PRE_D = 4'h7,
		S_SYNC_D = 4'h8,
		S_DATA = 4'h9,
		S_CRC = 4'ha,
		S_POST = 4'hb,
		S_TAIL = 4'hc
	} smf_state_t;

	// three-stage sync on servo, sector and index: two for metastability, one for edge history; unit select gets two
	logic [2:0] sclk_s;
	logic [2:0] sect_s;
	logic [2:0] idx_s;
	logic [1:0] usel_s;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sclk_s <= 3'h0;
			sect_s <= 3'h0;
			idx_s <= 3'h0;
			usel_s <= 2'h3;
		end else begin
			sclk_s <= {sclk_s[1:0], drv_i.servo_clk};
			sect_s <= {sect_s[1:0], drv_i.sector};
			idx_s <= {idx_s[1:0], drv_i.index};
			usel_s <= {usel_s[0], drv_i.unit_sel_n};
		end
	end
	wire sclk_rise = sclk_s[1] & ~sclk_s[2];
	wire mark_edge = (sect_s[1] & ~sect_s[2]) | (idx_s[1] & ~idx_s[2]);

	// unit-selected arrives inverted, so a low line means selected
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) selected_o <= 1'b0;
		else selected_o <= ~usel_s[1];
	end

	smf_state_t state;
	logic [31:0] wait_cnt;
	logic [2:0] bit_cnt;
	logic [15:0] byte_cnt;
	logic [7:0] shreg;
	logic chain;
	// keeps the gate up through the lead-in of a chained sector
	logic gate_hold;

	// byte source for the state just entered
	function automatic logic [7:0] byte_for(input smf_state_t s,
			input logic [15:0] n, input logic [31:0] a);
		case (s)
			S_SYNC_A, S_SYNC_D: byte_for = smf_pkg::SYNC_BYTE;
			S_ADDR: byte_for = a[8*n[1:0] +: 8];
			S_DATA: byte_for = smf_pkg::TEST_BYTE;
			S_CRC: byte_for = 8'h00;
			default: byte_for = smf_pkg::ZERO_BYTE;
		endcase
	endfunction

	// length of each byte-counted field
	function automatic logic [15:0] len_of(input smf_state_t s);
		case (s)
			S_PRE_A: len_of = 16'(smf_pkg::PRE_ADDR_ZEROS);
			S_ADDR: len_of = 16'h0004;
			S_PRE_D: len_of = 16'(smf_pkg::PRE_DATA_ZEROS);
			S_DATA: len_of = 16'(DATA_BYTES);
			S_CRC: len_of = 16'(smf_pkg::DATA_CRC_BYTES);
			S_POST: len_of = 16'(smf_pkg::POST_ZEROS);
			default: len_of = 16'h0001;
		endcase
	endfunction

	function automatic smf_state_t next_field(input smf_state_t s);
		case (s)
			S_PRE_A: next_field = S_SYNC_A;
			S_SYNC_A: next_field = S_ADDR;
			S_ADDR: next_field = S_PRE_D;
			S_PRE_D: next_field = S_SYNC_D;
			S_SYNC_D: next_field = S_DATA;
			S_DATA: next_field = S_CRC;
			S_CRC: next_field = S_POST;
			default: next_field = S_TAIL;
		endcase
	endfunction

	// running crc over data bytes, sent msb first in the check field
	logic [15:0] crc;
	function automatic logic [15:0] crc_step(input logic [15:0] c,
			input logic b);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h1021 : 16'h0000);
	endfunction

	wire field_st = (state >= S_PRE_A) && (state <= S_POST);
	wire byte_end = sclk_rise && (bit_cnt == 3'h7);
	wire last_byte = (byte_cnt == len_of(state) - 16'h0001);

	// main sequencer; bits advance on servo clock rise, eight per byte
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= S_IDLE;
			wait_cnt <= 32'h0;
			bit_cnt <= 3'h0;
			byte_cnt <= 16'h0;
			shreg <= 8'h00;
			chain <= 1'b0;
			gate_hold <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state)
				S_IDLE: begin
					if (start_i) begin
						chain <= chain_i;
						wait_cnt <= 32'h0;
						state <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					wait_cnt <= wait_cnt + 32'h1;
					if (wait_cnt >= HEAD_SETTLE - 1) state <= S_SEEK;
				end
				S_SEEK: begin
					// byte time counted from the mark edge
					if (mark_edge) state <= S_LEAD;
				end
				S_LEAD: begin
					// gate up on the next servo rise, so bit one gets a full cell
					if (sclk_rise) begin
						state <= S_PRE_A;
						gate_hold <= 1'b0;
						bit_cnt <= 3'h0;
						byte_cnt <= 16'h0;
						shreg <= smf_pkg::ZERO_BYTE;
					end
				end
				S_TAIL: begin
					// keep zeros and gate up until next mark if chaining
					if (!chain) begin
						done_o <= 1'b1;
						state <= S_IDLE;
					end else if (mark_edge) begin
						done_o <= 1'b1;
						chain <= chain_i;
						gate_hold <= 1'b1;
						state <= S_LEAD;
					end
				end
				default: begin
					if (sclk_rise) begin
						bit_cnt <= bit_cnt + 3'h1;
						shreg <= {shreg[6:0], 1'b0};
					end
					if (byte_end) begin
						if (last_byte) begin
							byte_cnt <= 16'h0;
							state <= next_field(state);
							shreg <= byte_for(next_field(state),
								16'h0, addr_i);
						end else begin
							byte_cnt <= byte_cnt + 16'h1;
							shreg <= byte_for(state,
								byte_cnt + 16'h1, addr_i);
						end
					end
				end
			endcase
		end
	end

	// crc accumulates data bits, then shifts out as the check bytes
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) crc <= 16'hffff;
		else if (state == S_SYNC_D) crc <= 16'hffff;
		else if (state == S_DATA && sclk_rise) crc <= crc_step(crc, shreg[7]);
		else if (state == S_CRC && sclk_rise) crc <= {crc[14:0], 1'b0};
	end

	// pins; data changes just after a servo rise, steady at the fall
	logic wdat;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) wdat <= 1'b0;
		else if (state == S_CRC) wdat <= crc[15];
		else wdat <= field_st ? shreg[7] : 1'b0;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drv_o <= '0;
			busy_o <= 1'b0;
		end else begin
			drv_o.write_data <= wdat;
			// servo clock echoed back continuously, well ahead of the gate
			drv_o.write_clk <= sclk_s[1];
			drv_o.write_gate <= field_st || (state == S_TAIL && chain) ||
				(state == S_LEAD && gate_hold);
			drv_o.read_gate <= 1'b0;
			drv_o.pwr_pick <= 1'b0;
			drv_o.pwr_hold <= 1'b0;
			busy_o <= (state != S_IDLE);
		end
	end
endmodule

// ==== bench/smf_format_ctrl_checker.sv ====
`timescale 1ns/1ps
module smf_format_ctrl_checker #(
	parameter int unsigned DATA_BYTES = 256,
	parameter int unsigned HEAD_SETTLE = smf_pkg::HEAD_SETTLE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// user side
	input wire logic start_i,
	input wire logic chain_i,
	input wire logic [31:0] addr_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic selected_o,
	// drive pins
	input wire smf_pkg::smf_drv_in_t drv_i,
	input wire smf_pkg::smf_drv_out_t drv_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	pwr_low_a: assert property (!drv_o.pwr_pick && !drv_o.pwr_hold)
		else $error("power sequence line high");
	gates_apart_a: assert property (!drv_o.read_gate)
		else $error("read gate raised");
	sel_on_a: assert property ($fell(drv_i.unit_sel_n) |-> ##[1:5] selected_o)
		else $error("selected not inverted");
	sel_off_a: assert property ($rose(drv_i.unit_sel_n) |-> ##[1:5] !selected_o)
		else $error("deselect not inverted");
	gate_busy_a: assert property (drv_o.write_gate |-> busy_o)
		else $error("write gate while idle");
	head_settle_a: assert property ($rose(busy_o) |-> !drv_o.write_gate [*8])
		else $error("write gate before settle");
	zero_lead_a: assert property ($rose(drv_o.write_gate) |-> !drv_o.write_data [*8])
		else $error("no leading zeros");
	wclk_echo_a: assert property ($rose(drv_i.servo_clk) |-> ##[1:6] drv_o.write_clk)
		else $error("write clock not echoed");
	done_pulse_a: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	gate_drop_a: assert property ($fell(drv_o.write_gate) |=> !busy_o)
		else $error("write gate dropped mid chain");
endmodule
bind smf_format_ctrl smf_format_ctrl_checker #(.DATA_BYTES(DATA_BYTES),
	.HEAD_SETTLE(HEAD_SETTLE)) u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
	.start_i(start_i), .chain_i(chain_i), .addr_i(addr_i), .busy_o(busy_o),
	.done_o(done_o), .selected_o(selected_o), .drv_i(drv_i), .drv_o(drv_o));

// ==== bench/smf_drive_model.sv ====
`timescale 1ns/1ps
module smf_drive_model (
	// controller pins
	input wire smf_pkg::smf_drv_out_t ctl_i,
	input wire logic sel_i,
	// drive pins, no busy line exists
	output smf_pkg::smf_drv_in_t drv_o
);
	logic srv = 0;
	logic idx = 0;
	logic sec = 0;
	logic ready;
	int unsigned cnt = 0;
	// read chain locks on zeros from read gate rise; this host never reads
	logic rd_lock = 0;
	always @(posedge ctl_i.read_gate) begin
		rd_lock = 0;
		#8000 rd_lock = ctl_i.read_gate;
	end
	// both power lines low keeps the drive sequenced up
	assign ready = !ctl_i.pwr_pick && !ctl_i.pwr_hold;
	// selected arrives inverted at the controller
	assign drv_o = '{srv, idx, sec, !sel_i};
	// servo clock free runs while ready, selected or not; 48 byte sectors
	initial begin
		#3;
		forever begin
			#80 srv = ready && !srv;
			if (srv) cnt = (cnt + 1) % 1536;
			sec = ready && (cnt % 384) < 16;
			idx = ready && cnt < 16;
		end
	end
endmodule

// ==== bench/smf_format_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module smf_format_ctrl_tb_top;
	localparam int NB = 2;
	localparam int LEN = 45 + NB;
	logic clk_i = 0, rstn_i = 0, start_i = 0, chain_i = 0, sel = 0;
	logic [31:0] addr_i = '0;
	logic busy_o, done_o, selected_o;
	smf_pkg::smf_drv_in_t drv_i;
	smf_pkg::smf_drv_out_t drv_o;
	logic q[$];
	int n_fail = 0, checks = 0, cyc = 0;
	smf_format_ctrl #(.DATA_BYTES(NB), .HEAD_SETTLE(20)) u_smf_format_ctrl (
		.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .chain_i(chain_i),
		.addr_i(addr_i), .busy_o(busy_o), .done_o(done_o),
		.selected_o(selected_o), .drv_i(drv_i), .drv_o(drv_o));
	smf_drive_model u_smf_drive_model (.ctl_i(drv_o), .sel_i(sel),
		.drv_o(drv_i));
	initial forever #2.5 clk_i = ~clk_i;
	// bits taken mid cell, well clear of the data change after a rise
	always @(negedge drv_i.servo_clk) if (drv_o.write_gate === 1)
		q.push_back(drv_o.write_data);
	// hang guard, above one revolution of waiting but short of two
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			finish_test();
		end
	end
	function automatic logic [7:0] exp_byte(int i, logic [31:0] a);
		if (i == 20 || i == 37) return smf_pkg::SYNC_BYTE;
		if (i > 20 && i < 25) return a[8*(i-21) +: 8];
		if (i > 37 && i < 38 + NB) return smf_pkg::TEST_BYTE;
		return smf_pkg::ZERO_BYTE;
	endfunction
	// crc16 ccitt over the test pattern, preset to all ones, msb first
	function automatic logic [15:0] exp_crc();
		logic [15:0] c;
		logic [7:0] t;
		c = 16'hffff;
		t = smf_pkg::TEST_BYTE;
		for (int i = 0; i < 8 * NB; i++)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ t[7 - i % 8]) ? 16'h1021 : 16'h0);
		return c;
	endfunction
	task chk(logic [15:0] got, logic [15:0] exp, string m);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	// outputs are read 1 ns after the edge that launches them
	task wait_done();
		for (int k = 0; k < 30000; k++) begin
			@(posedge clk_i);
			#1;
			if (done_o === 1) break;
		end
		chk(done_o, 1, "done pulse");
	endtask
	// one sector; a second start while busy must be ignored
	// chaining: chain is taken at start, dropped before the next mark
	task fmt(logic chn);
		logic [7:0] b;
		logic [15:0] c;
		c = exp_crc();
		q.delete();
		addr_i = $urandom;
		chain_i = chn;
		start_i = 1;
		@(posedge clk_i) #1 start_i = 0;
		chain_i = 0;
		repeat (50) @(posedge clk_i);
		#1 start_i = 1;
		@(posedge clk_i) #1 start_i = 0;
		wait_done();
		if (chn) begin
			repeat (16) @(posedge clk_i);
			#1 chk(drv_o.write_gate, 1, "gate kept on");
			wait_done();
		end else chk(q.size(), 8 * LEN, "gate length");
		for (int i = 0; i < LEN; i++) begin
			for (int j = 0; j < 8; j++) b[7-j] = q[8*i+j];
			if (i == 38 + NB) chk(b, c[15:8], "check high");
			else if (i == 39 + NB) chk(b, c[7:0], "check low");
			else chk(b, exp_byte(i, addr_i), "format byte");
		end
		repeat (40) @(posedge clk_i);
		#1 chk({busy_o, drv_o.write_gate}, 0, "back to idle");
	endtask
	task finish_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(78));
		repeat (4) @(posedge clk_i);
		#1 rstn_i = 1;
		chk({drv_o, busy_o, done_o}, 0, "reset outputs");
		for (int i = 0; i < 6; i++) begin
			sel = $urandom;
			repeat (8) @(posedge clk_i);
			#1 chk(selected_o, sel, "unit selected");
		end
		fmt(0);
		fmt(1);
		finish_test();
	end
endmodule
